// ### include/ham_pkg.sv
package ham_pkg;
   // register indices, byte address is four times the index
   localparam logic [5:0] IX_ADDR_CTL = 6'h01;
   localparam logic [5:0] IX_ADDR_LO = 6'h02;
   localparam logic [5:0] IX_ADDR_HI = 6'h09;
   localparam logic [5:0] IX_TX_LEN_LO = 6'h12;
   localparam logic [5:0] IX_TX_LEN_HI = 6'h13;
   localparam logic [5:0] IX_TX_THR = 6'h14;
   localparam logic [5:0] IX_MATCH = 6'h15;
   localparam logic [5:0] IX_RX_LEN_LO = 6'h16;
   localparam logic [5:0] IX_RX_LEN_HI = 6'h17;
   localparam logic [5:0] IX_LINK = 6'h19;
   localparam logic [5:0] IX_BUF = 6'h1a;
   localparam logic [5:0] IX_RX_DATA = 6'h1b;
   localparam logic [5:0] IX_TX_DATA = 6'h1c;
   localparam logic [5:0] IX_RX_THR = 6'h1e;
   // address match control fields
   localparam int AC_SECOND = 7;
   localparam int AC_CR_IGN = 6;
   localparam int AC_TWO = 5;
   localparam int AC_BC_EN = 4;
   localparam logic [7:0] AC_RST = 8'h00;
   // address byte bits
   localparam logic [7:0] CR_MASK = 8'hfd;
   localparam logic [7:0] BC_ONE = 8'hff;
   localparam logic [7:0] BC_TWO_FIRST = 8'hfe;
   // match report codes
   localparam logic [2:0] MC_BCAST = 3'b100;
   localparam logic [2:0] MC_NONE = 3'b110;
   localparam logic [2:0] MC_ALL_OFF = 3'b111;
   // buffer status bits
   localparam int BS_RX_AVAIL = 0;
   localparam int BS_RX_THR = 1;
   localparam int BS_RX_EOP = 2;
   localparam int BS_TX_AVAIL = 3;
   localparam int BS_TX_THR = 4;
   localparam int BS_TX_EMPTY = 5;
   // thresholds
   localparam logic [5:0] RX_THR_MIN = 6'h02;
   localparam logic [5:0] RX_THR_MAX = 6'h20;
   localparam logic [5:0] RX_THR_RST = 6'h10;
   localparam logic [3:0] TX_THR_RST = 4'h8;
   // buffer entry: byte plus end-of-packet marker
   typedef struct packed {
      logic eop;
      logic [7:0] data;
   } ham_ent_s;
   // receive transfer request states
   typedef enum logic [1:0] {
      RQ_IDLE = 2'b00,
      RQ_THR = 2'b01,
      RQ_EOP = 2'b10,
      RQ_HOLD = 2'b11
   } ham_rxq_e;
endpackage : ham_pkg

// ### rtl/ham_core.sv
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ham_core
   import ham_pkg::*;
#(
   parameter int RX_DEPTH = 32,
   parameter int TX_DEPTH = 16,
   parameter int LEN_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_frame_start_i,
   input wire logic rx_byte_stb_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_byte_last_i,
   output logic rx_transfer_request_o,
   input wire logic tx_transfer_ack_n_i,
   output logic tx_transfer_request_o,
   input wire logic tx_load_i,
   output logic [7:0] tx_byte_o,
   output logic tx_byte_last_o,
   output logic tx_byte_ready_o
);
   localparam int RPW = $clog2(RX_DEPTH);
   localparam int TPW = $clog2(TX_DEPTH);

   logic [7:0] ctl_r;
   logic [15:0] addr_r [4];
   logic [3:0] tx_thr_r;
   logic [5:0] rx_thr_r;
   logic [LEN_W-1:0] tx_len_r;
   logic [LEN_W-1:0] tx_rem_r;
   logic [LEN_W-1:0] rx_cnt_r;
   logic [LEN_W-1:0] rx_len_r;
   logic [2:0] code_r;
   logic [2:0] match_r;
   logic [7:0] first_r;
   logic [1:0] bidx_r;
   logic acc_r;
   logic in_frame_r;
   ham_ent_s pend_r;
   logic pend_v_r;
   logic flush_r;
   ham_ent_s rx_mem [RX_DEPTH];
   logic [RPW:0] rx_wp_r;
   logic [RPW:0] rx_rp_r;
   logic [RPW:0] rx_lvl;
   logic [RPW:0] eop_cnt_r;
   ham_rxq_e rxq_r;
   ham_ent_s tx_mem [TX_DEPTH];
   logic [TPW:0] tx_wp_r;
   logic [TPW:0] tx_rp_r;
   logic [TPW:0] tx_lvl;
   logic last_in_r;
   logic tx_req_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic take;
   logic wr;
   logic rd;
   logic [5:0] ix;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic rx_pop;
   logic rx_empty;
   logic tx_push;
   logic tx_pop;
   logic tx_full;
   logic [5:0] rx_thr_eff;
   logic dec_now;
   logic dec_ok;
   logic [2:0] dec_code;
   logic [7:0] b0;
   logic rx_wr;
   ham_ent_s rx_wdat;
   logic acc_now;

   // bus request decode, lane 0 carries the 8-bit registers
   assign take = wb_cyc_i && wb_stb_i && !ack_r && ce_i;
   assign wr = take && wb_we_i && wb_sel_i[0];
   assign rd = take && !wb_we_i;
   assign ix = wb_adr_i[7:2];
   assign wbyte = wb_dat_i[7:0];
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // buffer levels and thresholds
   assign rx_lvl = rx_wp_r - rx_rp_r;
   assign tx_lvl = tx_wp_r - tx_rp_r;
   assign rx_empty = (rx_lvl == '0);
   assign tx_full = (tx_lvl == (TPW+1)'(TX_DEPTH));
   assign rx_thr_eff = (rx_thr_r < RX_THR_MIN) ? RX_THR_MIN :
                       (rx_thr_r > RX_THR_MAX) ? RX_THR_MAX : rx_thr_r;
   assign rx_pop = rd && (ix == IX_RX_DATA) && !rx_empty;
   assign tx_push = wr && (ix == IX_TX_DATA) && !tx_full && (tx_rem_r != '0);
   assign tx_pop = ce_i && tx_load_i && (tx_lvl != '0);
   assign tx_byte_ready_o = (tx_lvl != '0);
   assign rx_transfer_request_o = (rxq_r == RQ_THR) || (rxq_r == RQ_EOP);
   assign tx_transfer_request_o = tx_req_r;

   // one detector compare, command/response bit optionally masked
   function automatic logic hit(input logic [15:0] a, input logic [7:0] f,
                                input logic [7:0] s, input logic [7:0] c);
      logic [7:0] m;
      m = c[AC_CR_IGN] ? CR_MASK : 8'hff;
      if (c[AC_TWO]) begin
         hit = (((a[7:0] ^ f) & m) == 8'h00) && (a[15:8] == s);
      end else if (c[AC_SECOND]) begin
         hit = (a[7:0] == s);
      end else begin
         hit = (((a[7:0] ^ f) & m) == 8'h00);
      end
   endfunction : hit

   // address decision on the second byte, or on a one-byte packet end
   always_comb begin
      b0 = (bidx_r == 2'd0) ? rx_byte_i : first_r;
      dec_now = rx_byte_stb_i && ((bidx_r == 2'd1) ||
                ((bidx_r == 2'd0) && rx_byte_last_i));
      dec_ok = 1'b0;
      dec_code = MC_NONE;
      if (ctl_r[4:0] == 5'h00) begin
         dec_ok = 1'b1;
         dec_code = MC_ALL_OFF;
      end else begin
         if (ctl_r[AC_BC_EN] && hit({BC_ONE, ctl_r[AC_TWO] ? BC_TWO_FIRST : BC_ONE},
             b0, rx_byte_i, ctl_r)) begin
            dec_ok = 1'b1;
            dec_code = MC_BCAST;
         end
         for (int i = 3; i >= 0; i--) begin
            if (ctl_r[i] && hit(addr_r[i], b0, rx_byte_i, ctl_r)) begin
               dec_ok = 1'b1;
               dec_code = 3'(i);
            end
         end
      end
   end

   // byte held back one slot so the decision precedes the first write
   always_comb begin
      acc_now = dec_now ? dec_ok : acc_r;
      rx_wr = 1'b0;
      rx_wdat = pend_r;
      if (flush_r) begin
         rx_wr = 1'b1;
      end else if (rx_byte_stb_i && in_frame_r && pend_v_r && acc_now) begin
         rx_wr = 1'b1;
      end
   end

   // receive framing state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_r <= 8'h00;
         bidx_r <= 2'd0;
         acc_r <= 1'b0;
         in_frame_r <= 1'b0;
         pend_r <= '0;
         pend_v_r <= 1'b0;
         flush_r <= 1'b0;
         code_r <= MC_NONE;
         rx_cnt_r <= '0;
      end else if (ce_i) begin
         flush_r <= 1'b0;
         if (flush_r) begin
            pend_v_r <= 1'b0;
         end
         if (rx_frame_start_i) begin
            bidx_r <= 2'd0;
            acc_r <= 1'b0;
            in_frame_r <= 1'b1;
            pend_v_r <= 1'b0;
            rx_cnt_r <= '0;
         end else if (rx_byte_stb_i && in_frame_r) begin
            if (bidx_r == 2'd0) begin
               first_r <= rx_byte_i;
            end
            if (bidx_r != 2'd2) begin
               bidx_r <= bidx_r + 2'd1;
            end
            if (dec_now) begin
               acc_r <= dec_ok;
               code_r <= dec_code;
            end
            if (acc_now || (bidx_r == 2'd0 && !rx_byte_last_i)) begin
               pend_r <= '{eop: rx_byte_last_i, data: rx_byte_i};
               pend_v_r <= 1'b1;
               rx_cnt_r <= rx_cnt_r + LEN_W'(1);
               flush_r <= rx_byte_last_i;
            end else begin
               pend_v_r <= 1'b0;
            end
            if (rx_byte_last_i) begin
               in_frame_r <= 1'b0;
            end
         end
      end
   end

   // receive buffer storage, overrun drops the byte
   always_ff @(posedge clk_i) begin
      if (ce_i && rx_wr && (rx_lvl != (RPW+1)'(RX_DEPTH))) begin
         rx_mem[rx_wp_r[RPW-1:0]] <= rx_wdat;
      end
   end

   // receive pointers and end marker count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_wp_r <= '0;
         rx_rp_r <= '0;
         eop_cnt_r <= '0;
      end else if (ce_i) begin
         if (rx_wr && (rx_lvl != (RPW+1)'(RX_DEPTH))) begin
            rx_wp_r <= rx_wp_r + (RPW+1)'(1);
         end
         if (rx_pop) begin
            rx_rp_r <= rx_rp_r + (RPW+1)'(1);
         end
         eop_cnt_r <= eop_cnt_r + (RPW+1)'(rx_wr && rx_wdat.eop)
                      - (RPW+1)'(rx_pop && rx_mem[rx_rp_r[RPW-1:0]].eop);
      end
   end

   // packet status, cleared by reading the low length byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_r <= MC_NONE;
         rx_len_r <= '0;
      end else if (ce_i) begin
         if (flush_r) begin
            match_r <= code_r;
            rx_len_r <= rx_cnt_r;
         end else if (rd && ix == IX_RX_LEN_LO) begin
            match_r <= MC_NONE;
            rx_len_r <= '0;
         end
      end
   end

   // receive transfer request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxq_r <= RQ_IDLE;
      end else if (ce_i) begin
         case (rxq_r)
            RQ_IDLE: begin
               if (eop_cnt_r != '0) begin
                  rxq_r <= RQ_EOP;
               end else if (rx_lvl >= (RPW+1)'(rx_thr_eff)) begin
                  rxq_r <= RQ_THR;
               end
            end
            RQ_THR: begin
               if (rx_pop && rx_mem[rx_rp_r[RPW-1:0]].eop) begin
                  rxq_r <= RQ_HOLD;
               end else if (rx_pop && rx_lvl == (RPW+1)'(1)) begin
                  rxq_r <= RQ_IDLE;
               end
            end
            RQ_EOP: begin
               if (rx_pop && rx_mem[rx_rp_r[RPW-1:0]].eop) begin
                  rxq_r <= RQ_HOLD;
               end
            end
            RQ_HOLD: begin
               if (rd && ix == IX_RX_LEN_LO) begin
                  rxq_r <= RQ_IDLE;
               end
            end
            default: begin
               rxq_r <= RQ_IDLE;
            end
         endcase
      end
   end

   // transmit buffer storage
   always_ff @(posedge clk_i) begin
      if (ce_i && tx_push) begin
         tx_mem[tx_wp_r[TPW-1:0]] <= '{eop: (tx_rem_r == LEN_W'(1)), data: wbyte};
      end
   end

   // transmit pointers, remaining count and serializer hand-off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_wp_r <= '0;
         tx_rp_r <= '0;
         tx_rem_r <= '0;
         last_in_r <= 1'b0;
         tx_byte_o <= 8'h00;
         tx_byte_last_o <= 1'b0;
      end else if (ce_i) begin
         if (tx_push) begin
            tx_wp_r <= tx_wp_r + (TPW+1)'(1);
            tx_rem_r <= tx_rem_r - LEN_W'(1);
            if (tx_rem_r == LEN_W'(1)) begin
               last_in_r <= 1'b1;
            end
         end
         if (tx_pop) begin
            tx_rp_r <= tx_rp_r + (TPW+1)'(1);
            tx_byte_o <= tx_mem[tx_rp_r[TPW-1:0]].data;
            tx_byte_last_o <= tx_mem[tx_rp_r[TPW-1:0]].eop;
            if (tx_mem[tx_rp_r[TPW-1:0]].eop) begin
               last_in_r <= 1'b0;
               tx_rem_r <= tx_len_r;
            end
         end
         if (wr && (ix == IX_TX_LEN_LO || ix == IX_TX_LEN_HI) &&
             tx_lvl == '0 && !last_in_r) begin
            tx_rem_r <= (ix == IX_TX_LEN_LO) ? {tx_len_r[LEN_W-1:8], wbyte} :
                        {wbyte, tx_len_r[7:0]};
         end
      end
   end

   // transmit transfer request, dropped early when a write is under way
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_req_r <= 1'b0;
      end else if (ce_i) begin
         tx_req_r <= (tx_rem_r != '0) && !tx_full && !tx_push &&
                     (tx_req_r || tx_lvl <= (TPW+1)'(tx_thr_r)) &&
                     !(!tx_transfer_ack_n_i && (tx_rem_r == LEN_W'(1) ||
                       tx_lvl == (TPW+1)'(TX_DEPTH - 1)));
      end
   end

   // software-written configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_r <= AC_RST;
         for (int i = 0; i < 4; i++) begin
            addr_r[i] <= 16'h0000;
         end
         tx_thr_r <= TX_THR_RST;
         rx_thr_r <= RX_THR_RST;
         tx_len_r <= '0;
      end else if (wr) begin
         if (ix == IX_ADDR_CTL) begin
            ctl_r <= wbyte;
         end
         if (ix >= IX_ADDR_LO && ix <= IX_ADDR_HI) begin
            if (ix[0]) begin
               addr_r[2'((ix - IX_ADDR_LO) >> 1)][15:8] <= wbyte;
            end else begin
               addr_r[2'((ix - IX_ADDR_LO) >> 1)][7:0] <= wbyte;
            end
         end
         if (ix == IX_TX_THR) begin
            tx_thr_r <= wbyte[3:0];
         end
         if (ix == IX_RX_THR) begin
            rx_thr_r <= wbyte[5:0];
         end
         if (ix == IX_TX_LEN_LO) begin
            tx_len_r[7:0] <= wbyte;
         end
         if (ix == IX_TX_LEN_HI) begin
            tx_len_r[LEN_W-1:8] <= wbyte[LEN_W-9:0];
         end
      end
   end

   // read data selection
   always_comb begin
      rbyte = 8'h00;
      case (ix)
         IX_ADDR_CTL: rbyte = ctl_r;
         IX_TX_LEN_LO: rbyte = tx_len_r[7:0];
         IX_TX_LEN_HI: rbyte = tx_len_r[LEN_W-1:8];
         IX_TX_THR: rbyte = {4'h0, tx_thr_r};
         IX_RX_THR: rbyte = {2'b00, rx_thr_r};
         IX_MATCH: rbyte = {5'h00, match_r};
         IX_RX_LEN_LO: rbyte = rx_len_r[7:0];
         IX_RX_LEN_HI: rbyte = rx_len_r[LEN_W-1:8];
         IX_LINK: rbyte = {6'h00, acc_r, in_frame_r};
         IX_BUF: begin
            rbyte[BS_RX_AVAIL] = !rx_empty && (rxq_r != RQ_HOLD);
            rbyte[BS_RX_THR] = (rx_lvl >= (RPW+1)'(rx_thr_eff));
            rbyte[BS_RX_EOP] = (eop_cnt_r != '0);
            rbyte[BS_TX_AVAIL] = !tx_full && (tx_rem_r != '0);
            rbyte[BS_TX_THR] = (tx_lvl <= (TPW+1)'(tx_thr_r));
            rbyte[BS_TX_EMPTY] = (tx_lvl == '0);
         end
         IX_RX_DATA: rbyte = rx_empty ? 8'h00 : rx_mem[rx_rp_r[RPW-1:0]].data;
         default: begin
            if (ix >= IX_ADDR_LO && ix <= IX_ADDR_HI) begin
               rbyte = ix[0] ? addr_r[2'((ix - IX_ADDR_LO) >> 1)][15:8] :
                       addr_r[2'((ix - IX_ADDR_LO) >> 1)][7:0];
            end
         end
      endcase
   end

   // wishbone answer one cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else if (ce_i) begin
         ack_r <= take;
         if (rd) begin
            dat_r <= {24'h000000, rbyte};
         end
      end
   end
endmodule : ham_core
`default_nettype wire

// ### sim/ham_core_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ham_core_properties
   import ham_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic rx_frame_start_i,
   input wire logic rx_byte_stb_i,
   input wire logic rx_transfer_request_o,
   input wire logic tx_transfer_request_o,
   input wire logic tx_load_i,
   input wire logic [7:0] tx_byte_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // requests quiet out of reset
   AST_RST_REQ: assert property (disable iff (1'b0) rst_i && ce_i |=>
      !rx_transfer_request_o && !tx_transfer_request_o) else $error("request after reset");
   // bus answer timing and width
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_TIME: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_RD_HI: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   // transmit request drops around a push
   AST_TX_PUSH: assert property (wb_ack_o && wb_we_i && wb_adr_i[7:2] == IX_TX_DATA
      |-> ##[0:1] !tx_transfer_request_o) else $error("tx request kept over push");
   AST_TX_HOLD: assert property (!tx_load_i |=> $stable(tx_byte_o))
      else $error("tx byte moved without load");
   // receive request edges need a cause
   AST_RX_RISE: assert property ($rose(rx_transfer_request_o) |-> $past(rx_byte_stb_i, 2)
      || $past(rx_byte_stb_i, 3) || $past(rx_byte_stb_i, 4) || $past(wb_ack_o)
      || $past(wb_ack_o, 2)) else $error("rx request rose without cause");
   AST_RX_FALL: assert property ($fell(rx_transfer_request_o) |-> $past(wb_cyc_i && wb_stb_i
      && !wb_we_i && !wb_ack_o && ce_i && wb_adr_i[7:2] == IX_RX_DATA))
      else $error("rx request fell without read");
endmodule : ham_core_properties
bind ham_core ham_core_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_frame_start_i(rx_frame_start_i),
   .rx_byte_stb_i(rx_byte_stb_i), .rx_transfer_request_o(rx_transfer_request_o),
   .tx_transfer_request_o(tx_transfer_request_o), .tx_load_i(tx_load_i),
   .tx_byte_o(tx_byte_o));
`default_nettype wire

// ### sim/ham_ser_model.sv
`timescale 1ns/10ps
`default_nettype none
module ham_ser_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic slow_i,
   input wire logic ready_i,
   input wire logic [7:0] byte_i,
   input wire logic last_i,
   output logic load_o,
   output logic ack_n_o
);
   logic [8:0] got [32];
   int n_got;
   logic [1:0] gap_r;
   logic took_r;
   // no acknowledge wire, bus cycles carry a wait state
   assign ack_n_o = 1'b1;
   // serializer pulls bytes, every other cycle or one in four
   always_ff @(posedge clk_i) begin
      gap_r <= rst_i ? 2'h0 : gap_r + 2'h1;
      load_o <= !rst_i && run_i && ready_i && !load_o && (!slow_i || gap_r == 2'h0);
      took_r <= load_o && !rst_i;
   end
   // collect what was shifted out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         n_got <= 0;
      end else if (took_r) begin
         got[n_got] <= {last_i, byte_i};
         n_got <= n_got + 1;
      end
   end
endmodule : ham_ser_model
`default_nettype wire

// ### sim/test_hdlc_addr_match_fifo_dma.sv
`timescale 1ns/10ps
`default_nettype none
module test_hdlc_addr_match_fifo_dma
   import ham_pkg::*;
;
   logic clk_i, rst_i, cyc, stb, we, rx_start, rx_stb, rx_last, run, slow, tx_load, ack_n;
   logic [7:0] adr, rx_byte, tx_byte;
   logic [3:0] sel;
   logic [31:0] dat, dat_o, rd;
   logic ack, rx_req, tx_req, tx_last, tx_rdy;
   int error_cnt, n_tests, cyc_cnt, i, k;
   // ctl, first byte, second byte, match code
   logic [31:0] tab [13] = '{32'h005a0107, 32'h01120000, 32'h01341206, 32'h41100000,
      32'h01100006, 32'h82995601, 32'h04770002, 32'h283ac503, 32'h283ac406,
      32'h10ff0004, 32'h30feff04, 32'h30ffff06, 32'h70fcff04};

   ham_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .rx_frame_start_i(rx_start), .rx_byte_stb_i(rx_stb),
      .rx_byte_i(rx_byte), .rx_byte_last_i(rx_last), .rx_transfer_request_o(rx_req),
      .tx_transfer_ack_n_i(ack_n), .tx_transfer_request_o(tx_req), .tx_load_i(tx_load),
      .tx_byte_o(tx_byte), .tx_byte_last_o(tx_last), .tx_byte_ready_o(tx_rdy));
   ham_ser_model i_ser (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .slow_i(slow),
      .ready_i(tx_rdy), .byte_i(tx_byte), .last_i(tx_last), .load_o(tx_load), .ack_n_o(ack_n));

   // clock and hang guard
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task finish_test;
      if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // one classic bus cycle, held until ack
   task wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1; adr <= {ix, 2'b00}; dat <= {24'h0, d};
      // ack and read data sampled at the edge that sees ack high
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      #1;
   endtask : wb
   task rdc(input logic [5:0] ix, input logic [7:0] m, input logic [7:0] e);
      wb(1'b0, ix, 8'h00);
      check(rd & {24'h0, m}, {24'h0, e});
   endtask : rdc
   // one received byte, strobes two cycles apart
   task rx_b(input logic [7:0] b, input logic l);
      @(posedge clk_i);
      rx_stb <= 1'b1; rx_byte <= b; rx_last <= l;
      @(posedge clk_i);
      rx_stb <= 1'b0; rx_last <= 1'b0;
   endtask : rx_b
   task rx_pkt(input logic [7:0] b0, input logic [7:0] b1);
      @(posedge clk_i);
      rx_start <= 1'b1;
      @(posedge clk_i);
      rx_start <= 1'b0;
      rx_b(b0, 1'b0);
      rx_b(b1, 1'b0);
      rx_b(8'h3c, 1'b1);
      repeat (4) @(posedge clk_i);
      #1;
   endtask : rx_pkt
   task drain(input logic [7:0] b0, input logic [7:0] b1);
      rdc(IX_RX_DATA, 8'hff, b0);
      rdc(IX_RX_DATA, 8'hff, b1);
      rdc(IX_RX_DATA, 8'hff, 8'h3c);
   endtask : drain

   initial begin
      {cyc, stb, we, rx_start, rx_stb, rx_last, run, slow} = '0;
      {adr, rx_byte, sel, dat} = '0;
      rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check({rx_req, tx_req}, 2'b00);
      rdc(IX_MATCH, 8'h07, MC_NONE);
      rdc(IX_ADDR_CTL, 8'hff, AC_RST);
      rdc(IX_TX_THR, 8'h0f, 8'h08);
      rdc(IX_RX_THR, 8'h3f, 8'h10);
      rdc(6'h3f, 8'hff, 8'h00);
      // detector addresses
      wb(1'b1, 6'h02, 8'h12);
      wb(1'b1, 6'h04, 8'h56);
      wb(1'b1, 6'h06, 8'h77);
      wb(1'b1, 6'h08, 8'h3a);
      wb(1'b1, 6'h09, 8'hc5);
      rdc(6'h09, 8'hff, 8'hc5);
      // address modes and match codes
      for (k = 0; k < 13; k++) begin
         wb(1'b1, IX_ADDR_CTL, tab[k][31:24]);
         rdc(IX_ADDR_CTL, 8'hff, tab[k][31:24]);
         rx_pkt(tab[k][23:16], tab[k][15:8]);
         rdc(IX_MATCH, 8'h07, tab[k][7:0]);
         check(rx_req, tab[k][2:0] != MC_NONE);
         if (tab[k][2:0] != MC_NONE) drain(tab[k][23:16], tab[k][15:8]);
         wb(1'b0, IX_RX_LEN_LO, 8'h00);
      end
      // two packets queued: packet boundary interlock
      wb(1'b1, IX_ADDR_CTL, 8'h00);
      rx_pkt(8'h11, 8'h22);
      rx_pkt(8'h33, 8'h44);
      rdc(IX_BUF, 8'h05, 8'h05);
      drain(8'h11, 8'h22);
      #1;
      check(rx_req, 1'b0);
      rdc(IX_BUF, 8'h01, 8'h00);
      check(rx_req, 1'b0);
      rdc(IX_RX_LEN_LO, 8'hff, 8'h03);
      repeat (2) @(posedge clk_i);
      #1;
      check(rx_req, 1'b1);
      rdc(IX_BUF, 8'h01, 8'h01);
      drain(8'h33, 8'h44);
      wb(1'b0, IX_RX_LEN_LO, 8'h00);
      // threshold request until empty
      wb(1'b1, IX_RX_THR, 8'h02);
      rx_pkt(8'h55, 8'h66);
      drain(8'h55, 8'h66);
      wb(1'b0, IX_RX_LEN_LO, 8'h00);
      @(posedge clk_i);
      rx_start <= 1'b1;
      @(posedge clk_i);
      rx_start <= 1'b0;
      for (i = 0; i < 3; i++) rx_b(8'h70 + i[7:0], 1'b0);
      repeat (3) @(posedge clk_i);
      #1;
      check(rx_req, 1'b1);
      rdc(IX_BUF, 8'h02, 8'h02);
      rdc(IX_RX_DATA, 8'hff, 8'h70);
      rdc(IX_RX_DATA, 8'hff, 8'h71);
      #1;
      check(rx_req, 1'b0);
      rx_b(8'h73, 1'b1);
      repeat (3) @(posedge clk_i);
      rdc(IX_RX_DATA, 8'hff, 8'h72);
      rdc(IX_RX_DATA, 8'hff, 8'h73);
      wb(1'b0, IX_RX_LEN_LO, 8'h00);
      // transmit: count gating, reload, one packet in buffer
      wb(1'b1, IX_TX_LEN_LO, 8'h03);
      wb(1'b1, IX_TX_LEN_HI, 8'h00);
      repeat (2) @(posedge clk_i);
      #1;
      check(tx_req, 1'b1);
      rdc(IX_BUF, 8'h08, 8'h08);
      for (i = 0; i < 3; i++) wb(1'b1, IX_TX_DATA, 8'ha0 + i[7:0]);
      #1;
      check(tx_req, 1'b0);
      rdc(IX_BUF, 8'h08, 8'h00);
      wb(1'b1, IX_TX_LEN_LO, 8'h02);
      repeat (2) @(posedge clk_i);
      #1;
      check(tx_req, 1'b0);
      run <= 1'b1;
      while (i_ser.n_got < 3) @(posedge clk_i);
      repeat (3) @(posedge clk_i);
      #1;
      check({i_ser.got[0], i_ser.got[1], i_ser.got[2]}, 27'h28143a2);
      check(tx_req, 1'b1);
      wb(1'b1, IX_TX_DATA, 8'hb0);
      wb(1'b1, IX_TX_DATA, 8'hb1);
      while (i_ser.n_got < 5) @(posedge clk_i);
      run <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(i_ser.got[4], 9'h1b1);
      // fill to full with the far side stalled
      wb(1'b1, IX_TX_LEN_LO, 8'h14);
      i = 0;
      do begin
         wb(1'b1, IX_TX_DATA, i[7:0]);
         i++;
         wb(1'b0, IX_BUF, 8'h00);
      end while (rd[BS_TX_AVAIL] && i < 20);
      check(i, 16);
      check(tx_rdy, 1'b1);
      #1;
      check(tx_req, 1'b0);
      slow <= 1'b1;
      run <= 1'b1;
      while (tx_req !== 1'b1) @(posedge clk_i);
      rdc(IX_BUF, 8'h10, 8'h10);
      while (i < 20) begin
         wb(1'b0, IX_BUF, 8'h00);
         if (rd[BS_TX_AVAIL]) begin
            wb(1'b1, IX_TX_DATA, i[7:0]);
            i++;
         end
      end
      while (i_ser.n_got < 25) @(posedge clk_i);
      #1;
      check({i_ser.got[23], i_ser.got[24]}, 18'h02513);
      check(tx_rdy, 1'b0);
      finish_test();
   end
endmodule : test_hdlc_addr_match_fifo_dma
`default_nettype wire
